// [include/icm_regs.svh]
`ifndef ICM_REGS_SVH
`define ICM_REGS_SVH
// ==========================================
// register offsets on the serial port
`define ICM_SAMPLE_MODE_OFF 8'h09
`define ICM_OFFSET_TRIM_OFF 8'h10
`define ICM_FINE_TRIM_OFF 8'h37
`define ICM_COARSE_TRIM_OFF 8'h38
// ==========================================
// field positions and reset values
`define ICM_INTERLEAVE_BIT 3
`define ICM_SAMPLE_MODE_RST 8'h08
`define ICM_TRIM_RST 8'h00
`endif

// [include/icm_pkg.sv]
package icm_pkg;
  // clocking mode of the two cores
  typedef enum logic [1:0] {
    ICM_INTERLEAVED = 2'b00,
    ICM_DUAL_SHARED = 2'b01,
    ICM_DUAL_AUX = 2'b11
  } icm_mode_type;
  // register write request from the serial port
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] data;
  } icm_wr_type;
  // per core timing trims
  typedef struct packed {
    logic [3:0] coarse;
    logic [3:0] fine;
  } icm_trim_type;
endpackage

// [hdl/icm_sync3.sv]
// three stage synchroniser; change counted when stages two and three agree
module icm_sync3 (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic async_in,
  output logic sync_out
);
  // ==========================================
  // shift chain
  logic s1_r;
  logic s2_r;
  logic s3_r;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      s1_r <= async_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      // hold until two late stages agree
      if (s2_r == s3_r) begin
        sync_out <= s3_r;
      end
    end
  end
endmodule

// [hdl/icm_clock_mode.sv]
`include "icm_regs.svh"
// ==========================================
// Overview of operation
// - reset comes up interleaved, one channel
// - full clock split into two opposite phases
// - fine and coarse trims in separate registers
// - simultaneous plus select high uses aux clock
// - aux phase 0/180; data realigned to pair
// - simultaneous, select low: both cores share clock
// - aux mode bypasses internal delay trims
// - channel offset correction register
// - output disable high floats both buses
module icm_clock_mode #(
  parameter int DATA_W = 8
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire icm_pkg::icm_wr_type reg_wr,
  input wire logic [7:0] reg_rd_addr,
  output logic [7:0] reg_rd_data,
  input wire logic second_clock_select,
  input wire logic output_disable_n_pin,
  input wire logic aux_clk_level,
  input wire logic [DATA_W-1:0] core_a_data,
  input wire logic [DATA_W-1:0] core_b_data,
  output logic core_a_clk_en,
  output logic core_b_clk_en,
  output logic core_b_from_aux,
  output logic trim_bypass,
  output icm_pkg::icm_trim_type trim_a,
  output icm_pkg::icm_trim_type trim_b,
  output logic [7:0] offset_trim,
  output icm_pkg::icm_mode_type mode,
  output logic [DATA_W-1:0] out_a_data,
  output logic [DATA_W-1:0] out_b_data,
  output logic out_valid,
  output logic out_oe
);
  // ==========================================
  // elaboration check
  if (DATA_W < 1 || DATA_W > 16) begin : g_bad_width
    $error("DATA_W out of range");
  end

  // ==========================================
  // registers
  logic [7:0] sample_mode_r; // sample mode config
  logic [7:0] offset_r; // channel offset trim
  logic [7:0] fine_r; // fine delay trim, a low b high
  logic [7:0] coarse_r; // coarse delay trim, a low b high

  // register writes
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sample_mode_r <= `ICM_SAMPLE_MODE_RST; // interleave on
      offset_r <= `ICM_TRIM_RST;
      fine_r <= `ICM_TRIM_RST;
      coarse_r <= `ICM_TRIM_RST;
    end else if (reg_wr.wr) begin
      unique case (reg_wr.addr)
        `ICM_SAMPLE_MODE_OFF: sample_mode_r <= reg_wr.data;
        `ICM_OFFSET_TRIM_OFF: offset_r <= reg_wr.data;
        `ICM_FINE_TRIM_OFF: fine_r <= reg_wr.data;
        `ICM_COARSE_TRIM_OFF: coarse_r <= reg_wr.data;
        default: ;
      endcase
    end
  end

  // register readback
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rd_data <= 8'h00;
    end else begin
      unique case (reg_rd_addr)
        `ICM_SAMPLE_MODE_OFF: reg_rd_data <= sample_mode_r;
        `ICM_OFFSET_TRIM_OFF: reg_rd_data <= offset_r;
        `ICM_FINE_TRIM_OFF: reg_rd_data <= fine_r;
        `ICM_COARSE_TRIM_OFF: reg_rd_data <= coarse_r;
        default: reg_rd_data <= 8'h00;
      endcase
    end
  end

  // ==========================================
  // pin synchronisers
  logic aux_sel_s; // synced select pin
  logic oe_n_s; // synced output disable
  icm_sync3 u_sync_sel (
    .core_clk(core_clk),
    .resetn(resetn),
    .async_in(second_clock_select),
    .sync_out(aux_sel_s)
  );
  icm_sync3 u_sync_oe (
    .core_clk(core_clk),
    .resetn(resetn),
    .async_in(output_disable_n_pin),
    .sync_out(oe_n_s)
  );

  // ==========================================
  // mode decode
  icm_pkg::icm_mode_type mode_nxt;
  always_comb begin
    if (sample_mode_r[`ICM_INTERLEAVE_BIT]) begin
      mode_nxt = icm_pkg::ICM_INTERLEAVED;
    end else if (aux_sel_s) begin
      mode_nxt = icm_pkg::ICM_DUAL_AUX;
    end else begin
      mode_nxt = icm_pkg::ICM_DUAL_SHARED;
    end
  end

  // mode register
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      mode <= icm_pkg::ICM_INTERLEAVED;
    end else begin
      mode <= mode_nxt;
    end
  end

  // ==========================================
  // half rate phase toggle
  logic phase_r;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      phase_r <= 1'b0;
    end else begin
      phase_r <= ~phase_r; // divide by two
    end
  end

  // aux clock level capture, phase relation kept by source
  logic aux_q_r;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      aux_q_r <= 1'b0;
    end else begin
      aux_q_r <= aux_clk_level;
    end
  end

  // ==========================================
  // core clock steering
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      core_a_clk_en <= 1'b0;
      core_b_clk_en <= 1'b0;
      core_b_from_aux <= 1'b0;
      trim_bypass <= 1'b0;
    end else begin
      unique case (mode_nxt)
        icm_pkg::ICM_INTERLEAVED: begin
          core_a_clk_en <= ~phase_r; // opposite phases
          core_b_clk_en <= phase_r;
          core_b_from_aux <= 1'b0;
          trim_bypass <= 1'b0;
        end
        icm_pkg::ICM_DUAL_SHARED: begin
          core_a_clk_en <= 1'b1; // same instant
          core_b_clk_en <= 1'b1;
          core_b_from_aux <= 1'b0;
          trim_bypass <= 1'b1;
        end
        icm_pkg::ICM_DUAL_AUX: begin
          core_a_clk_en <= ~phase_r; // half rate each
          core_b_clk_en <= aux_q_r;
          core_b_from_aux <= 1'b1;
          trim_bypass <= 1'b1;
        end
        default: begin
          core_a_clk_en <= 1'b0;
          core_b_clk_en <= 1'b0;
          core_b_from_aux <= 1'b0;
          trim_bypass <= 1'b1;
        end
      endcase
    end
  end

  // ==========================================
  // delay trims to delay lines, zeroed on bypass; offset trim always copied through
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      trim_a <= '0;
      trim_b <= '0;
      offset_trim <= 8'h00;
    end else begin
      offset_trim <= offset_r;
      if (mode_nxt == icm_pkg::ICM_INTERLEAVED) begin
        trim_a <= {coarse_r[3:0], fine_r[3:0]};
        trim_b <= {coarse_r[7:4], fine_r[7:4]};
      end else begin
        trim_a <= '0;
        trim_b <= '0;
      end
    end
  end

  // ==========================================
  // output alignment
  logic [DATA_W-1:0] hold_a_r; // core a sample awaiting partner
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      hold_a_r <= '0;
      out_a_data <= '0;
      out_b_data <= '0;
      out_valid <= 1'b0;
    end else begin
      if (core_a_clk_en) begin
        hold_a_r <= core_a_data;
      end
      if (mode == icm_pkg::ICM_INTERLEAVED) begin
        // a then b alternation in time order
        out_valid <= 1'b1;
        out_a_data <= phase_r ? core_b_data : core_a_data;
        out_b_data <= phase_r ? hold_a_r : core_b_data;
      end else if (mode == icm_pkg::ICM_DUAL_AUX) begin
        // pair both cores per half-rate slot
        out_valid <= core_b_clk_en;
        out_a_data <= hold_a_r;
        out_b_data <= core_b_data;
      end else begin
        out_valid <= 1'b1;
        out_a_data <= core_a_data;
        out_b_data <= core_b_data;
      end
    end
  end

  // ==========================================
  // output enable, disable pin active high floats buses
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      out_oe <= 1'b0;
    end else begin
      out_oe <= ~oe_n_s;
    end
  end
endmodule

// [bench/icm_checker.sv]
// ==========
// protocol checker on the block ports
module icm_checker (
  input wire logic core_clk,
  input wire logic resetn,
  input wire icm_pkg::icm_wr_type reg_wr,
  input wire logic second_clock_select,
  input wire logic output_disable_n_pin,
  input wire logic core_a_clk_en,
  input wire logic core_b_clk_en,
  input wire logic core_b_from_aux,
  input wire logic trim_bypass,
  input wire icm_pkg::icm_trim_type trim_a,
  input wire icm_pkg::icm_trim_type trim_b,
  input wire logic [7:0] offset_trim,
  input wire icm_pkg::icm_mode_type mode,
  input wire logic out_oe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  a_reset_mode: assert property ($rose(resetn) |-> mode == icm_pkg::ICM_INTERLEAVED)
    else $error("mode not interleaved after reset");
  a_split_phase: assert property ((mode == icm_pkg::ICM_INTERLEAVED)[*4] |->
    (core_a_clk_en ^ core_b_clk_en) && core_a_clk_en != $past(core_a_clk_en))
    else $error("core strobes not alternating");
  a_shared_strobe: assert property ((mode == icm_pkg::ICM_DUAL_SHARED)[*3] |->
    core_a_clk_en == core_b_clk_en) else $error("shared strobes differ");
  a_aux_route: assert property ((mode == icm_pkg::ICM_DUAL_AUX)[*2] |->
    core_b_from_aux && trim_bypass) else $error("aux routing missing");
  a_trim_zero: assert property ((mode != icm_pkg::ICM_INTERLEAVED)[*2] |->
    trim_a == 8'h00 && trim_b == 8'h00) else $error("trims active outside interleave");
  a_float_out: assert property ($stable(output_disable_n_pin)[*7] |->
    out_oe == !output_disable_n_pin) else $error("output enable wrong");
  a_offset_copy: assert property (reg_wr.wr && reg_wr.addr == 8'h10 |->
    ##2 offset_trim == $past(reg_wr.data, 2)) else $error("offset trim not copied");
  a_mode_pin: assert property ($stable(second_clock_select)[*7] ##0
    mode != icm_pkg::ICM_INTERLEAVED |-> mode[1] == second_clock_select)
    else $error("mode ignores select pin");
  c_aux: cover property (mode == icm_pkg::ICM_DUAL_AUX);
  c_shared: cover property (mode == icm_pkg::ICM_DUAL_SHARED);
  c_float: cover property (!out_oe);
endmodule
bind icm_clock_mode icm_checker i_icm_checker (.core_clk, .resetn, .reg_wr,
  .second_clock_select, .output_disable_n_pin, .core_a_clk_en, .core_b_clk_en,
  .core_b_from_aux, .trim_bypass, .trim_a, .trim_b, .offset_trim, .mode, .out_oe);

// [bench/icm_partner.sv]
// ==========
// board straps and auxiliary clock source
module icm_partner (
  input wire logic core_clk,
  input wire logic aux_on,
  input wire logic aux_phase,
  input wire logic disable_req,
  output logic second_clock_select = 1'b0,
  output logic output_disable_n_pin = 1'b0,
  output logic aux_clk_level = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  logic half_r = 1'b0; // half rate phase
  // straps follow board setting; aux clock parked low when unused
  always @(posedge core_clk) begin
    second_clock_select <= aux_on;
    output_disable_n_pin <= disable_req;
    half_r <= ~half_r;
    aux_clk_level <= aux_on & (half_r ^ aux_phase);
  end
endmodule

// [bench/tb_top.sv]
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(a, e) check_val(32'(a), 32'(e))
  logic core_clk = 1'b0, resetn = 1'b0, aux_on = 1'b0, aux_phase = 1'b0, disable_req = 1'b0;
  icm_pkg::icm_wr_type reg_wr = '0;
  logic [7:0] reg_rd_addr = 8'h00, core_a_data = 8'h00, core_b_data = 8'h00;
  logic [7:0] reg_rd_data, offset_trim, out_a_data, out_b_data;
  logic core_a_clk_en, core_b_clk_en, core_b_from_aux, trim_bypass, out_valid, out_oe;
  logic second_clock_select, output_disable_n_pin, aux_clk_level;
  icm_pkg::icm_trim_type trim_a, trim_b;
  icm_pkg::icm_mode_type mode;
  logic [31:0] seed = 32'h0d76;
  int fails = 0, cmp_count = 0, cycles = 0;
  icm_clock_mode #(.DATA_W(8)) i_icm_clock_mode (.core_clk, .resetn, .reg_wr, .reg_rd_addr,
    .reg_rd_data, .second_clock_select, .output_disable_n_pin, .aux_clk_level, .core_a_data,
    .core_b_data, .core_a_clk_en, .core_b_clk_en, .core_b_from_aux, .trim_bypass, .trim_a,
    .trim_b, .offset_trim, .mode, .out_a_data, .out_b_data, .out_valid, .out_oe);
  icm_partner i_icm_partner (.core_clk, .aux_on, .aux_phase, .disable_req,
    .second_clock_select, .output_disable_n_pin, .aux_clk_level);
  always #2.5 core_clk = ~core_clk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic logic [7:0] exp_trim(input logic [7:0] c, f, input logic hi);
    return hi ? {c[7:4], f[7:4]} : {c[3:0], f[3:0]};
  endfunction
  function automatic icm_pkg::icm_mode_type exp_mode(input logic b3, input logic sel);
    if (b3) return icm_pkg::ICM_INTERLEAVED;
    return sel ? icm_pkg::ICM_DUAL_AUX : icm_pkg::ICM_DUAL_SHARED;
  endfunction
  // random core samples and hang guard
  always @(posedge core_clk) begin
    seed <= xs(seed);
    core_a_data <= seed[7:0];
    core_b_data <= seed[15:8];
    cycles++;
    if (cycles == 4000) begin
      fails++;
      conclude();
    end
  end
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr <= '{1'b1, a, d};
    tick(1);
    reg_wr.wr <= 1'b0;
    tick(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_rd_addr <= a;
    tick(2);
    `CHK(reg_rd_data, e);
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    logic [7:0] f, c, o, p;
    for (int r = 0; r < 2; r++) begin
      resetn <= 1'b0;
      tick(20);
      resetn <= 1'b1;
      tick(2);
      `CHK(mode, icm_pkg::ICM_INTERLEAVED);
      rd(8'h09, 8'h08);
      `CHK(core_a_clk_en ^ core_b_clk_en, 1'b1);
      for (int i = 0; i < 4; i++) begin
        f = (i == 0) ? 8'hff : seed[23:16];
        c = (i == 0) ? 8'h00 : seed[31:24];
        o = seed[15:8];
        wr(8'h37, f);
        wr(8'h38, c);
        wr(8'h10, o);
        wr(8'h20, 8'hff);
        rd(8'h37, f);
        rd(8'h38, c);
        rd(8'h10, o);
        rd(8'h20, 8'h00);
        `CHK(trim_a, exp_trim(c, f, 1'b0));
        `CHK(trim_b, exp_trim(c, f, 1'b1));
        `CHK(offset_trim, o);
      end
      $display("test registers done");
      for (int m = 0; m < 3; m++) begin
        aux_on <= (m == 1);
        aux_phase <= seed[0];
        wr(8'h09, (m == 2) ? 8'h08 : 8'h00);
        tick(8);
        `CHK(mode, exp_mode(m == 2, m == 1));
        `CHK(core_b_from_aux, m == 1);
        `CHK(trim_a, (m == 2) ? exp_trim(c, f, 1'b0) : 8'h00);
        if (m != 0) `CHK(trim_bypass, m == 1);
        if (m != 1) `CHK(core_a_clk_en ^ core_b_clk_en, m == 2);
        o = core_a_data;
        p = core_b_data;
        tick(1);
        if (m == 0) `CHK(out_a_data, o);
        if (m == 0) `CHK(out_b_data, p);
        if (m == 2) `CHK((out_a_data == o) || (out_a_data == p), 1'b1);
        if (m != 1) `CHK(out_valid, 1'b1);
      end
      $display("test modes done");
      disable_req <= 1'b1;
      tick(8);
      `CHK(out_oe, 1'b0);
      disable_req <= 1'b0;
      tick(8);
      `CHK(out_oe, 1'b1);
      $display("test output enable done");
    end
    conclude();
  end
endmodule
